/* File: design/aes_block_encrypt_pkg.sv */
// Constants shared by the block encryption unit and its round engine.
package aes_block_encrypt_pkg;

	// Register byte offsets within the unit.
	localparam logic [11:0] OFF_START_TASK = 12'h000;
	localparam logic [11:0] OFF_ABORT_TASK = 12'h004;
	localparam logic [11:0] OFF_DONE_EVENT = 12'h100;
	localparam logic [11:0] OFF_ERROR_EVENT = 12'h104;
	localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'h304;
	localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'h308;
	localparam logic [11:0] OFF_STRUCT_POINTER = 12'h504;

	// Field positions and reset values.
	localparam int EN_DONE_BIT = 0;
	localparam int EN_ERROR_BIT = 1;
	localparam logic [1:0] ENABLE_RESET = 2'h0;
	localparam logic [31:0] POINTER_RESET = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Layout of the key, cleartext and ciphertext structure in RAM.
	localparam logic [31:0] KEY_OFFSET = 32'h0000_0000;
	localparam logic [31:0] CLEARTEXT_OFFSET = 32'h0000_0010;
	localparam logic [31:0] CIPHERTEXT_OFFSET = 32'h0000_0020;
	localparam logic [2:0] FETCH_LAST_WORD = 3'h7;
	localparam logic [2:0] STORE_LAST_WORD = 3'h3;

	// Cipher constants.
	localparam logic [3:0] AES_LAST_ROUND = 4'ha;
	localparam logic [7:0] RCON_FIRST = 8'h01;
	localparam logic [7:0] AES_POLY = 8'h1b;
	localparam logic [7:0] SBOX_AFFINE = 8'h63;

	// Longest run time of one block, from start to completion.
	localparam int CLK_PERIOD_NS = 20;
	localparam int BLOCK_MAX_TIME_NS = 7200;
	localparam int BLOCK_MAX_CYCLES = BLOCK_MAX_TIME_NS / CLK_PERIOD_NS;
	localparam logic [8:0] BLOCK_TIMEOUT = 9'(BLOCK_MAX_CYCLES - 1);

	// Sequencer states, Gray coded along idle, fetch, cipher, store.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_CIPHER = 2'b11,
		ST_STORE = 2'b10
	} seq_state_type;

endpackage : aes_block_encrypt_pkg

/* File: design/aes_round_engine.sv */
// Iterative AES-128 encryption engine, one round per clock cycle.
`timescale 1ns/1ns
module aes_round_engine
	import aes_block_encrypt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic abort,
	input wire logic [127:0] key,
	input wire logic [127:0] cleartext,
	output logic busy,
	output logic done,
	output logic [127:0] result
);

	logic [127:0] state_q, state_d;
	logic [127:0] rkey_q, rkey_d;
	logic [7:0] rcon_q, rcon_d;
	logic [3:0] round_q, round_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [127:0] shifted;
	logic [127:0] mixed;
	logic [127:0] next_key;
	logic [31:0] sub_word;

	// Multiply by x in the AES field.
	function automatic logic [7:0] xtime(input logic [7:0] a);
		xtime = {a[6:0], 1'b0} ^ (a[7] ? AES_POLY : 8'h00);
	endfunction : xtime

	// Full field multiply, shift and add.
	function automatic logic [7:0] gmul(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] acc;
		logic [7:0] p;
		acc = 8'h00;
		p = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				acc = acc ^ p;
			end
			p = xtime(p);
		end
		gmul = acc;
	endfunction : gmul

	// Substitution box: inverse as x to the 254th, then the affine map.
	function automatic logic [7:0] sbox(input logic [7:0] x);
		logic [7:0] inv;
		logic [7:0] p;
		inv = 8'h01;
		p = x;
		for (int i = 1; i < 8; i++) begin
			p = gmul(p, p);
			inv = gmul(inv, p);
		end
		sbox = inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]}
			^ {inv[4:0], inv[7:5]} ^ {inv[3:0], inv[7:4]} ^ SBOX_AFFINE;
	endfunction : sbox

	// Byte i sits at bits 127-8i; row is i mod 4, column is i div 4.
	for (genvar i = 0; i < 16; i++) begin : g_byte
		localparam int R = i % 4;
		localparam int C = i / 4;
		localparam int SRC = R + 4 * ((C + R) % 4);
		assign shifted[127 - 8 * i -: 8] = sbox(state_q[127 - 8 * SRC -: 8]);
	end

	// Column mixing; skipped in the last round.
	for (genvar c = 0; c < 4; c++) begin : g_col
		logic [7:0] b0, b1, b2, b3;
		assign b0 = shifted[127 - 32 * c -: 8];
		assign b1 = shifted[119 - 32 * c -: 8];
		assign b2 = shifted[111 - 32 * c -: 8];
		assign b3 = shifted[103 - 32 * c -: 8];
		assign mixed[127 - 32 * c -: 8] = xtime(b0 ^ b1) ^ b1 ^ b2 ^ b3;
		assign mixed[119 - 32 * c -: 8] = xtime(b1 ^ b2) ^ b2 ^ b3 ^ b0;
		assign mixed[111 - 32 * c -: 8] = xtime(b2 ^ b3) ^ b3 ^ b0 ^ b1;
		assign mixed[103 - 32 * c -: 8] = xtime(b3 ^ b0) ^ b0 ^ b1 ^ b2;
	end

	// Key expansion on the fly: rotated, substituted last word.
	for (genvar k = 0; k < 4; k++) begin : g_key
		assign sub_word[31 - 8 * k -: 8] =
			sbox(rkey_q[31 - 8 * ((k + 1) % 4) -: 8]);
	end
	assign next_key[127:96] = rkey_q[127:96] ^ sub_word ^ {rcon_q, 24'h00_0000};
	assign next_key[95:64] = rkey_q[95:64] ^ next_key[127:96];
	assign next_key[63:32] = rkey_q[63:32] ^ next_key[95:64];
	assign next_key[31:0] = rkey_q[31:0] ^ next_key[63:32];

	// Round sequencing; encryption only, no inverse path exists.
	always_comb begin
		state_d = state_q;
		rkey_d = rkey_q;
		rcon_d = rcon_q;
		round_d = round_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (abort) begin
			busy_d = 1'b0;
		end else if (start) begin
			state_d = cleartext ^ key;
			rkey_d = key;
			rcon_d = RCON_FIRST;
			round_d = 4'h1;
			busy_d = 1'b1;
		end else if (busy_q) begin
			rkey_d = next_key;
			rcon_d = xtime(rcon_q);
			if (round_q == AES_LAST_ROUND) begin
				state_d = shifted ^ next_key;
				busy_d = 1'b0;
				done_d = 1'b1;
			end else begin
				state_d = mixed ^ next_key;
				round_d = round_q + 4'h1;
			end
		end
	end

	// Engine registers.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '0;
			rkey_q <= '0;
			rcon_q <= RCON_FIRST;
			round_q <= 4'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rkey_q <= rkey_d;
			rcon_q <= rcon_d;
			round_q <= round_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;
	assign result = state_q;

endmodule : aes_round_engine

/* File: design/aes_block_encrypt_unit.sv */
// Block encryption unit: APB registers, RAM fetch and store, sequencing.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns

// What this block does
// - Start while core busy gives error only.
// - Stop task aborts run, raising error event.
// - Start task at 0x000, stop at 0x004.
// - Done flag at 0x100, set on completion.
// - Error flag at 0x104, set on abort.
// - Enable set 0x304, clear 0x308, bits 0,1.
// - Structure pointer at 0x504, resets to zero.
// - One block takes at most 7.2 us.
// - Fetch by DMA; done after ciphertext stored.
// - Lowest core priority; claim aborts with error.
// - AES-128 encryption only, no decryption.
module aes_block_encrypt_unit
	import aes_block_encrypt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic start_trigger,
	input wire logic abort_trigger,
	input wire logic core_busy,
	input wire logic core_claim,
	output logic core_in_use,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	output logic done_pulse,
	output logic error_pulse,
	output logic irq
);

	seq_state_type st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [8:0] timer_q, timer_d;
	logic [31:0] words_q [8];
	logic [31:0] words_d [8];
	logic req_q, req_d;
	logic we_q, we_d;
	logic [31:0] addr_q, addr_d;
	logic [31:0] wdata_q, wdata_d;
	logic in_use_q, in_use_d;
	logic done_pulse_q, done_pulse_d;
	logic error_pulse_q, error_pulse_d;
	logic ev_done_q, ev_done_d;
	logic ev_error_q, ev_error_d;
	logic [1:0] enable_q, enable_d;
	logic [31:0] pointer_q, pointer_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic irq_q, irq_d;
	logic eng_start;
	logic eng_abort;
	logic eng_busy;
	logic eng_done;
	logic [127:0] eng_key;
	logic [127:0] eng_text;
	logic [127:0] eng_result;
	logic [31:0] result_words [4];
	logic wr_acc;
	logic setup;
	logic start_hit;
	logic abort_hit;

	// RAM bytes are little endian within a word; cipher byte 0 is MSB.
	for (genvar i = 0; i < 16; i++) begin : g_pack
		assign eng_key[127 - 8 * i -: 8] = words_q[i / 4][8 * (i % 4) +: 8];
		assign eng_text[127 - 8 * i -: 8] = words_q[4 + i / 4][8 * (i % 4) +: 8];
		assign result_words[i / 4][8 * (i % 4) +: 8] = eng_result[127 - 8 * i -: 8];
	end

	aes_round_engine u_engine (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(eng_start),
		.abort(eng_abort),
		.key(eng_key),
		.cleartext(eng_text),
		.busy(eng_busy),
		.done(eng_done),
		.result(eng_result)
	);

	// Bus decode; the access phase always completes without wait states.
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pready_q & pwrite;
	assign start_hit = start_trigger | (wr_acc && paddr == OFF_START_TASK);
	assign abort_hit = abort_trigger | (wr_acc && paddr == OFF_ABORT_TASK);

	// Sequencer: fetch eight words, run the engine, store four words.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		words_d = words_q;
		req_d = req_q;
		we_d = we_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		eng_start = 1'b0;
		eng_abort = 1'b0;
		done_pulse_d = 1'b0;
		error_pulse_d = 1'b0;
		timer_d = (st_q == ST_IDLE) ? 9'h000 : timer_q + 9'h001;
		if (st_q != ST_IDLE && (abort_hit || core_claim
			|| timer_q == BLOCK_TIMEOUT)) begin
			st_d = ST_IDLE;
			req_d = 1'b0;
			we_d = 1'b0;
			eng_abort = 1'b1;
			error_pulse_d = 1'b1;
		end else begin
			if (start_hit && st_q != ST_IDLE) begin
				error_pulse_d = 1'b1;
			end
			unique case (st_q)
				ST_IDLE: begin
					if (start_hit && core_busy) begin
						error_pulse_d = 1'b1;
					end else if (start_hit) begin
						st_d = ST_FETCH;
						cnt_d = 3'h0;
						req_d = 1'b1;
						we_d = 1'b0;
						addr_d = pointer_q + KEY_OFFSET;
					end
				end
				ST_FETCH: begin
					if (req_q && mem_ack) begin
						words_d[cnt_q] = mem_rdata;
						req_d = 1'b0;
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == FETCH_LAST_WORD) begin
							st_d = ST_CIPHER;
							cnt_d = 3'h0;
						end
					end else if (!req_q) begin
						req_d = 1'b1;
						addr_d = pointer_q + {27'h000_0000, cnt_q, 2'b00};
					end
				end
				ST_CIPHER: begin
					if (cnt_q == 3'h0) begin
						eng_start = 1'b1;
						cnt_d = 3'h1;
					end else if (eng_done && !eng_busy) begin
						st_d = ST_STORE;
						cnt_d = 3'h0;
						req_d = 1'b1;
						we_d = 1'b1;
						addr_d = pointer_q + CIPHERTEXT_OFFSET;
						wdata_d = result_words[0];
					end
				end
				ST_STORE: begin
					if (req_q && mem_ack) begin
						req_d = 1'b0;
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == STORE_LAST_WORD) begin
							st_d = ST_IDLE;
							we_d = 1'b0;
							done_pulse_d = 1'b1;
						end
					end else if (!req_q) begin
						req_d = 1'b1;
						addr_d = pointer_q + CIPHERTEXT_OFFSET
							+ {27'h000_0000, cnt_q, 2'b00};
						wdata_d = result_words[cnt_q[1:0]];
					end
				end
			endcase
		end
		in_use_d = (st_d != ST_IDLE);
	end

	// Sequencer registers.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_IDLE;
			cnt_q <= 3'h0;
			timer_q <= 9'h000;
			for (int w = 0; w < 8; w++) begin
				words_q[w] <= 32'h0000_0000;
			end
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
			in_use_q <= 1'b0;
			done_pulse_q <= 1'b0;
			error_pulse_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			timer_q <= timer_d;
			words_q <= words_d;
			req_q <= req_d;
			we_q <= we_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			in_use_q <= in_use_d;
			done_pulse_q <= done_pulse_d;
			error_pulse_q <= error_pulse_d;
		end
	end

	// Register file, event flags and interrupt; a new event beats a clear.
	always_comb begin
		pointer_d = pointer_q;
		enable_d = enable_q;
		ev_done_d = ev_done_q;
		ev_error_d = ev_error_q;
		if (wr_acc) begin
			unique case (paddr)
				OFF_DONE_EVENT: begin
					if (!pwdata[0]) begin
						ev_done_d = 1'b0;
					end
				end
				OFF_ERROR_EVENT: begin
					if (!pwdata[0]) begin
						ev_error_d = 1'b0;
					end
				end
				OFF_IRQ_ENABLE_SET: begin
					enable_d = enable_q | pwdata[1:0];
				end
				OFF_IRQ_ENABLE_CLEAR: begin
					enable_d = enable_q & ~pwdata[1:0];
				end
				OFF_STRUCT_POINTER: begin
					pointer_d = pwdata;
				end
				default: begin
				end
			endcase
		end
		if (done_pulse_d) begin
			ev_done_d = 1'b1;
		end
		if (error_pulse_d) begin
			ev_error_d = 1'b1;
		end
		irq_d = (ev_done_d & enable_d[EN_DONE_BIT])
			| (ev_error_d & enable_d[EN_ERROR_BIT]);
		pready_d = setup;
		pslverr_d = 1'b0;
		prdata_d = READ_ZERO;
		if (setup) begin
			unique case (paddr)
				OFF_START_TASK, OFF_ABORT_TASK: prdata_d = READ_ZERO;
				OFF_DONE_EVENT: prdata_d = {31'h0000_0000, ev_done_q};
				OFF_ERROR_EVENT: prdata_d = {31'h0000_0000, ev_error_q};
				OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR: begin
					prdata_d = {30'h0000_0000, enable_q};
				end
				OFF_STRUCT_POINTER: prdata_d = pointer_q;
				default: pslverr_d = 1'b1;
			endcase
		end
	end

	// Register file registers.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pointer_q <= POINTER_RESET;
			enable_q <= ENABLE_RESET;
			ev_done_q <= 1'b0;
			ev_error_q <= 1'b0;
			irq_q <= 1'b0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= READ_ZERO;
		end else begin
			pointer_q <= pointer_d;
			enable_q <= enable_d;
			ev_done_q <= ev_done_d;
			ev_error_q <= ev_error_d;
			irq_q <= irq_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign core_in_use = in_use_q;
	assign mem_req = req_q;
	assign mem_we = we_q;
	assign mem_addr = addr_q;
	assign mem_wdata = wdata_q;
	assign done_pulse = done_pulse_q;
	assign error_pulse = error_pulse_q;
	assign irq = irq_q;

endmodule : aes_block_encrypt_unit

/* File: verif/aes_block_encrypt_unit_asserts.sv */
// Port timing checks of the block encryption unit.
`timescale 1ns/1ns
module aes_block_encrypt_unit_asserts
	import aes_block_encrypt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic start_trigger,
	input wire logic abort_trigger,
	input wire logic core_busy,
	input wire logic core_claim,
	input wire logic core_in_use,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic done_pulse,
	input wire logic error_pulse
);
	logic [9:0] run_q;
	logic [9:0] run_d;

	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// Counts the cycles of the current run.
	always_comb begin
		run_d = core_in_use ? run_q + 10'h1 : 10'h0;
	end

	// Registers the run length.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			run_q <= 10'h0;
		end else begin
			run_q <= run_d;
		end
	end

	AST_PREADY: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_SLVERR: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_BUSY: assert property (start_trigger && core_busy && !core_in_use
		|=> error_pulse && !core_in_use)
		else $error("start while core busy");
	AST_ABORT: assert property (core_in_use && abort_trigger
		|=> error_pulse && !done_pulse && !core_in_use)
		else $error("stop did not abort");
	AST_CLAIM: assert property (core_in_use && core_claim
		|=> error_pulse && !mem_req)
		else $error("claim did not abort");
	AST_DONE: assert property (done_pulse
		|-> $past(mem_ack && mem_we) && !error_pulse)
		else $error("done before last store");
	AST_ONE: assert property (done_pulse |=> !done_pulse)
		else $error("done longer than one cycle");
	AST_HOLD: assert property (mem_req && !mem_ack && !abort_trigger
		&& !core_claim && !psel |=> mem_req && $stable(mem_addr))
		else $error("request dropped early");
	AST_RUN: assert property (run_q <= BLOCK_MAX_CYCLES)
		else $error("run too long");
endmodule : aes_block_encrypt_unit_asserts

/* File: verif/ram_model.sv */
// System RAM with a settable reply delay.
`timescale 1ns/1ns
module ram_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [2:0] lag,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [31:0] mem [64];
	logic [2:0] cnt;

	// Answers after lag cycles; read data is scrambled outside the ack.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mem_ack <= 1'b0;
			cnt <= 3'h0;
			mem_rdata <= 32'h5a5a_5a5a;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (!mem_req || mem_ack) begin
				cnt <= 3'h0;
			end else if (cnt < lag) begin
				cnt <= cnt + 3'h1;
			end else begin
				mem_ack <= 1'b1;
				mem_rdata <= mem[mem_addr[7:2]];
				if (mem_we) begin
					mem[mem_addr[7:2]] <= mem_wdata;
				end
			end
		end
	end
endmodule : ram_model

/* File: verif/aes_block_encrypt_unit_test.sv */
// Register level bench of the block encryption unit.
`timescale 1ns/1ns
module aes_block_encrypt_unit_test import aes_block_encrypt_pkg::*;;
	logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic start_trigger = 0, abort_trigger = 0, core_busy = 0;
	logic core_claim = 0, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, mem_addr, mem_wdata, mem_rdata, rv;
	logic pready, pslverr, core_in_use, mem_req, mem_we, mem_ack;
	logic done_pulse, error_pulse, irq;
	logic [2:0] lag = 0;
	int err_count = 0, checked = 0, cyc = 0, n;
	localparam logic [31:0] CT [4] = '{32'hd8e0_c469, 32'h3004_7b6a,
		32'h80b7_cdd8, 32'h5ac5_b470};

	aes_block_encrypt_unit dut (.ref_clk, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .start_trigger,
		.abort_trigger, .core_busy, .core_claim, .core_in_use, .mem_req,
		.mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .done_pulse,
		.error_pulse, .irq);
	ram_model ram (.ref_clk, .resetn, .lag, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack);

	// Free running clock and a cycle ceiling against hangs.
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("BAD %0t saw %h want %h", $time, s, e);
		end
	endtask : chk

	// One APB transfer, then an idle cycle.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask : rd

	// One-cycle pulse on a hardware pin: 0 start, 1 stop, 2 claim.
	task automatic pulse(input int which);
		if (which == 0) begin
			start_trigger <= 1'b1;
		end else if (which == 1) begin
			abort_trigger <= 1'b1;
		end else begin
			core_claim <= 1'b1;
		end
		@(posedge ref_clk);
		start_trigger <= 1'b0;
		abort_trigger <= 1'b0;
		core_claim <= 1'b0;
	endtask : pulse

	// Waits for the end of a run, done or error.
	task automatic wait_end();
		n = 0;
		while (done_pulse !== 1'b1 && error_pulse !== 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		// A run that never ends is a failure in its own right.
		if (n == 1000) begin
			err_count++;
			$display("BAD %0t run did not end", $time);
			end_of_test();
		end
	endtask : wait_end

	// Reset, register checks, good runs, aborted runs, busy core.
	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(OFF_IRQ_ENABLE_SET, 32'h0);
		rd(OFF_STRUCT_POINTER, POINTER_RESET);
		rd(OFF_DONE_EVENT, 32'h0);
		rd(OFF_ERROR_EVENT, 32'h0);
		rd(OFF_START_TASK, 32'h0);
		rd(12'h200, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, OFF_STRUCT_POINTER, 32'h40);
		rd(OFF_STRUCT_POINTER, 32'h40);
		apb(1'b1, OFF_IRQ_ENABLE_SET, 32'h3);
		apb(1'b1, OFF_IRQ_ENABLE_CLEAR, 32'h2);
		apb(1'b1, OFF_IRQ_ENABLE_SET, 32'h0);
		rd(OFF_IRQ_ENABLE_CLEAR, 32'h1);
		rd(OFF_IRQ_ENABLE_SET, 32'h1);
		for (int i = 0; i < 4; i++) begin
			ram.mem[16 + i] = 32'h0302_0100 + 32'h0404_0404 * i;
			ram.mem[20 + i] = 32'h3322_1100 + 32'h4444_4444 * i;
		end
		for (int i = 0; i < 2; i++) begin
			lag <= 3'(3 * i);
			for (int j = 0; j < 4; j++) begin
				ram.mem[24 + j] = 32'h0;
			end
			if (i == 0) begin
				apb(1'b1, OFF_START_TASK, 32'h1);
			end else begin
				pulse(0);
			end
			wait_end();
			chk({31'h0, n <= BLOCK_MAX_CYCLES}, 32'h1);
			rd(OFF_DONE_EVENT, 32'h1);
			rd(OFF_ERROR_EVENT, 32'h0);
			chk({31'h0, irq}, 32'h1);
			for (int j = 0; j < 4; j++) begin
				chk(ram.mem[24 + j], CT[j]);
			end
			apb(1'b1, OFF_DONE_EVENT, 32'h0);
			chk({31'h0, irq}, 32'h0);
		end
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, OFF_START_TASK, 32'h1);
			repeat (6) @(posedge ref_clk);
			if (k == 0) begin
				apb(1'b1, OFF_ABORT_TASK, 32'h1);
			end else begin
				pulse(k);
			end
			wait_end();
			chk({31'h0, error_pulse}, 32'h1);
			rd(OFF_ERROR_EVENT, 32'h1);
			rd(OFF_DONE_EVENT, 32'h0);
			chk({31'h0, irq}, 32'h0);
			apb(1'b1, OFF_ERROR_EVENT, 32'h1);
			rd(OFF_ERROR_EVENT, 32'h1);
			apb(1'b1, OFF_ERROR_EVENT, 32'h0);
			rd(OFF_ERROR_EVENT, 32'h0);
		end
		core_busy <= 1'b1;
		pulse(0);
		wait_end();
		chk({31'h0, error_pulse}, 32'h1);
		chk({31'h0, core_in_use}, 32'h0);
		core_busy <= 1'b0;
		rd(OFF_ERROR_EVENT, 32'h1);
		// A second start during our own run flags an error, run goes on.
		pulse(0);
		repeat (4) @(posedge ref_clk);
		pulse(0);
		wait_end();
		chk({31'h0, error_pulse}, 32'h1);
		chk({31'h0, core_in_use}, 32'h1);
		@(posedge ref_clk);
		wait_end();
		chk({31'h0, done_pulse}, 32'h1);
		rd(OFF_DONE_EVENT, 32'h1);
		end_of_test();
	end
endmodule : aes_block_encrypt_unit_test

bind aes_block_encrypt_unit aes_block_encrypt_unit_asserts chk_i (.ref_clk,
	.resetn, .psel, .penable, .pready, .pslverr, .start_trigger,
	.abort_trigger, .core_busy, .core_claim, .core_in_use, .mem_req,
	.mem_we, .mem_addr, .mem_ack, .done_pulse, .error_pulse);
